// *** include/pcss_params.svh ***
// offsets, field positions, reset values and counts for the port strobe block
`ifndef PCSS_PARAMS_SVH
`define PCSS_PARAMS_SVH

// ==========================================================================
// register indices (byte address is four times the index)
`define PCSS_IDX_POLARITY   8'hAE
`define PCSS_IDX_CTRL_LO    8'hC2
`define PCSS_IDX_CTRL_HI    8'hC3
`define PCSS_IDX_PORT_DATA  8'hD8
`define PCSS_IDX_P0_BASE_LO 8'h84
`define PCSS_IDX_P0_BASE_HI 8'h85
`define PCSS_IDX_P1_BASE_LO 8'h94
`define PCSS_IDX_P1_BASE_HI 8'h95
`define PCSS_IDX_P2_BASE_LO 8'hAC
`define PCSS_IDX_P2_BASE_HI 8'hAD
`define PCSS_IDX_P3_BASE_LO 8'hB4
`define PCSS_IDX_P3_BASE_HI 8'hB5

// ==========================================================================
// field positions
`define PCSS_NPINS          4
`define PCSS_FLD_PER_PIN    4
`define PCSS_FUNC_LSB       2
`define PCSS_CMP_LSB        0
`define PCSS_POL_LSB        4
`define PCSS_POL_MASK       8'hF0

// ==========================================================================
// reset values
`define PCSS_RST_CTRL       8'h00
`define PCSS_RST_POL        4'h0
`define PCSS_RST_BASE       16'h0000
`define PCSS_RST_DATA       4'hF

`endif

// *** include/pcss_pkg.sv ***
// types shared by the port strobe block
package pcss_pkg;

  // ========================================================================
  // pin function and compare length
  typedef enum logic [1:0] {
    PCSS_FUNC_GPIO,
    PCSS_FUNC_RD,
    PCSS_FUNC_WR,
    PCSS_FUNC_RDWR
  } pcss_func_e;

  typedef enum logic [1:0] {
    PCSS_CMP_A15_A0,
    PCSS_CMP_A15_A1,
    PCSS_CMP_A15_A2,
    PCSS_CMP_A15_A8
  } pcss_cmp_e;

  // ========================================================================
  // register decode result
  typedef enum logic [2:0] {
    PCSS_REG_NONE,
    PCSS_REG_POL,
    PCSS_REG_CTRL_LO,
    PCSS_REG_CTRL_HI,
    PCSS_REG_DATA,
    PCSS_REG_BASE_LO,
    PCSS_REG_BASE_HI
  } pcss_reg_e;

endpackage

// *** src/pcss_addr_match.sv ***
// address comparator for one strobe pin
`timescale 1ns/100ps

module pcss_addr_match (
  input  wire logic [15:0]        bus_addr,
  input  wire logic [15:0]        base_addr,
  input  wire pcss_pkg::pcss_cmp_e cmp_len,
  output logic                    addr_hit
);

  logic [15:0] care_mask;

  // ========================================================================
  // excluded low bits are don't-care
  always_comb begin
    unique case (cmp_len)
      pcss_pkg::PCSS_CMP_A15_A0: care_mask = 16'hFFFF; // RQ5
      pcss_pkg::PCSS_CMP_A15_A1: care_mask = 16'hFFFE; // RQ6
      pcss_pkg::PCSS_CMP_A15_A2: care_mask = 16'hFFFC; // RQ7
      pcss_pkg::PCSS_CMP_A15_A8: care_mask = 16'hFF00; // RQ8
    endcase
  end

  assign addr_hit = ((bus_addr ^ base_addr) & care_mask) == 16'h0000; // RQ16

endmodule // pcss_addr_match

// *** src/pcss_sync3.sv ***
// three-stage pin synchroniser, change accepted when stages two and three agree
`timescale 1ns/100ps

module pcss_sync3 #(
  parameter int WIDTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] rst_val,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  // ========================================================================
  // stage one feeds stage two only
  always_ff @(posedge clk) begin
    // stages start at the idle level, else readback dips right after reset
    if (rst) begin
      s1_reg <= rst_val;
      s2_reg <= rst_val;
      s3_reg <= rst_val;
    end else if (ce) begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // ========================================================================
  // per-bit agreement filter
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge clk) begin
        if (rst) begin
          sync_out[g] <= rst_val[g];
        end else if (ce && (s2_reg[g] == s3_reg[g])) begin
          sync_out[g] <= s3_reg[g];
        end
      end
    end
  endgenerate

endmodule // pcss_sync3

// *** src/pcss_port_strobe.sv ***
// four-pin port with address-decoded chip-select strobes and an apb register file
//
// Operation
// RQ1: function code 00 makes the pin a quasi-bidirectional gpio bit.
// RQ2: function code 01 strobes the pin on matching external reads.
// RQ3: function code 10 strobes the pin on matching external writes.
// RQ4: function code 11 strobes the pin on matching reads and writes.
// RQ5: compare code 00 matches all sixteen address bits.
// RQ6: compare code 01 ignores address bit 0.
// RQ7: compare code 10 ignores address bits 1 and 0.
// RQ8: compare code 11 matches only the high address byte.
// RQ9: high control register: pin3 function 7:6, length 5:4; pin2 3:2, 1:0.
// RQ10: low control register: pin1 function 7:6, length 5:4; pin0 3:2, 1:0.
// RQ11: polarity bit 7 sets pin3 strobe level, one is active high.
// RQ12: polarity bits 6, 5, 4 set pins 2, 1, 0 strobe level.
// RQ13: each pin has a sixteen-bit base from high and low byte registers.
// RQ14: strobes follow the core read or write strobe of the matching cycle.
// RQ15: in gpio mode port data bits 3:0 drive the pins.
// RQ16: strobe pins idle at inactive level; excluded address bits are don't-care.
// RQ17: all control, polarity and base registers clear to zero on reset.
`timescale 1ns/100ps
`include "pcss_params.svh"

module pcss_port_strobe #(
  parameter int PADDR_W = 12
) (
  input  wire logic               CLK_SYS,
  input  wire logic               SYS_RST,
  input  wire logic               CLK_EN,
  input  wire logic               PSEL,
  input  wire logic               PENABLE,
  input  wire logic               PWRITE,
  input  wire logic [PADDR_W-1:0] PADDR,
  input  wire logic [31:0]        PWDATA,
  input  wire logic [3:0]         PSTRB,
  output logic      [31:0]        PRDATA,
  output logic                    PREADY,
  output logic                    PSLVERR,
  input  wire logic [15:0]        BUS_ADDR,
  input  wire logic               BUS_RD,
  input  wire logic               BUS_WR,
  input  wire logic [3:0]         PIN_IN,
  output logic      [3:0]         PIN_OUT,
  output logic      [3:0]         PIN_OE
);

  localparam int NP = `PCSS_NPINS;

  // ==========================================================================
  // declarations
  logic [7:0]  ctrl_lo_reg;
  logic [7:0]  ctrl_hi_reg;
  logic [3:0]  pol_reg;
  logic [3:0]  data_reg;
  logic [15:0] base_reg [NP];
  logic [3:0]  pin_level;

  logic                  acc_phase;
  logic                  wr_fire;
  logic                  pready_next;
  logic [31:0]           rd_word;
  pcss_pkg::pcss_reg_e   wr_sel;
  pcss_pkg::pcss_reg_e   rd_sel;
  logic [1:0]            wr_pin;
  logic [1:0]            rd_pin;
  logic [15:0]           ctrl_word;
  logic [NP-1:0]         addr_hit;
  logic [NP-1:0]         strobe_act;
  pcss_pkg::pcss_func_e  pin_func [NP];
  pcss_pkg::pcss_cmp_e   pin_cmp  [NP];

  // ==========================================================================
  // address decode, used by both the write and the read path
  function automatic pcss_pkg::pcss_reg_e reg_decode(input logic [PADDR_W-1:0] addr);
    logic [7:0] idx;
    idx = addr[9:2];
    reg_decode = pcss_pkg::PCSS_REG_NONE;
    if ((addr[1:0] == 2'h0) && (addr[PADDR_W-1:10] == '0)) begin
      unique case (idx)
        `PCSS_IDX_POLARITY:   reg_decode = pcss_pkg::PCSS_REG_POL;
        `PCSS_IDX_CTRL_LO:    reg_decode = pcss_pkg::PCSS_REG_CTRL_LO;
        `PCSS_IDX_CTRL_HI:    reg_decode = pcss_pkg::PCSS_REG_CTRL_HI;
        `PCSS_IDX_PORT_DATA:  reg_decode = pcss_pkg::PCSS_REG_DATA;
        `PCSS_IDX_P0_BASE_LO,
        `PCSS_IDX_P1_BASE_LO,
        `PCSS_IDX_P2_BASE_LO,
        `PCSS_IDX_P3_BASE_LO: reg_decode = pcss_pkg::PCSS_REG_BASE_LO;
        `PCSS_IDX_P0_BASE_HI,
        `PCSS_IDX_P1_BASE_HI,
        `PCSS_IDX_P2_BASE_HI,
        `PCSS_IDX_P3_BASE_HI: reg_decode = pcss_pkg::PCSS_REG_BASE_HI;
        default:              reg_decode = pcss_pkg::PCSS_REG_NONE;
      endcase
    end
  endfunction

  function automatic logic [1:0] pin_decode(input logic [PADDR_W-1:0] addr);
    logic [7:0] idx;
    idx = addr[9:2];
    unique case (idx)
      `PCSS_IDX_P1_BASE_LO, `PCSS_IDX_P1_BASE_HI: pin_decode = 2'h1;
      `PCSS_IDX_P2_BASE_LO, `PCSS_IDX_P2_BASE_HI: pin_decode = 2'h2;
      `PCSS_IDX_P3_BASE_LO, `PCSS_IDX_P3_BASE_HI: pin_decode = 2'h3;
      default:                                    pin_decode = 2'h0;
    endcase
  endfunction

  // ==========================================================================
  // apb handshake: one wait cycle, write lands on the pready edge
  assign acc_phase   = PSEL && PENABLE;
  assign pready_next = acc_phase && !PREADY;
  assign wr_fire     = acc_phase && PREADY && PWRITE && PSTRB[0];
  assign wr_sel      = reg_decode(PADDR);
  assign rd_sel      = wr_sel;
  assign wr_pin      = pin_decode(PADDR);
  assign rd_pin      = wr_pin;

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      PREADY <= 1'b0;
    end else if (CLK_EN) begin
      PREADY <= pready_next;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      PSLVERR <= 1'b0;
    end else if (CLK_EN) begin
      PSLVERR <= pready_next && (rd_sel == pcss_pkg::PCSS_REG_NONE);
    end
  end

  // ==========================================================================
  // read mux; reserved polarity bits read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (rd_sel)
      pcss_pkg::PCSS_REG_POL:     rd_word[7:0] = {pol_reg, 4'h0};
      pcss_pkg::PCSS_REG_CTRL_LO: rd_word[7:0] = ctrl_lo_reg;
      pcss_pkg::PCSS_REG_CTRL_HI: rd_word[7:0] = ctrl_hi_reg;
      pcss_pkg::PCSS_REG_DATA:    rd_word[3:0] = pin_level;
      pcss_pkg::PCSS_REG_BASE_LO: rd_word[7:0] = base_reg[rd_pin][7:0];
      pcss_pkg::PCSS_REG_BASE_HI: rd_word[7:0] = base_reg[rd_pin][15:8];
      pcss_pkg::PCSS_REG_NONE:    rd_word = 32'h0000_0000;
    endcase
  end

  // data captured one cycle early, held while the request stands
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      PRDATA <= 32'h0000_0000;
    end else if (CLK_EN && pready_next) begin
      PRDATA <= PWRITE ? 32'h0000_0000 : rd_word;
    end
  end

  // ==========================================================================
  // control registers
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ctrl_lo_reg <= `PCSS_RST_CTRL; // RQ17
    end else if (CLK_EN && wr_fire && (wr_sel == pcss_pkg::PCSS_REG_CTRL_LO)) begin
      ctrl_lo_reg <= PWDATA[7:0]; // RQ10
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ctrl_hi_reg <= `PCSS_RST_CTRL; // RQ17
    end else if (CLK_EN && wr_fire && (wr_sel == pcss_pkg::PCSS_REG_CTRL_HI)) begin
      ctrl_hi_reg <= PWDATA[7:0]; // RQ9
    end
  end

  // only the upper nibble is storage, the rest is fixed zero
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      pol_reg <= `PCSS_RST_POL; // RQ17
    end else if (CLK_EN && wr_fire && (wr_sel == pcss_pkg::PCSS_REG_POL)) begin
      pol_reg <= PWDATA[7:4]; // RQ11 RQ12
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      data_reg <= `PCSS_RST_DATA;
    end else if (CLK_EN && wr_fire && (wr_sel == pcss_pkg::PCSS_REG_DATA)) begin
      data_reg <= PWDATA[3:0]; // RQ15
    end
  end

  // ==========================================================================
  // base address registers, one byte lane each
  genvar gb;
  generate
    for (gb = 0; gb < NP; gb++) begin : g_base
      always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
          base_reg[gb] <= `PCSS_RST_BASE; // RQ17
        end else if (CLK_EN && wr_fire && (wr_pin == 2'(gb))) begin
          if (wr_sel == pcss_pkg::PCSS_REG_BASE_HI) begin
            base_reg[gb][15:8] <= PWDATA[7:0]; // RQ13
          end else if (wr_sel == pcss_pkg::PCSS_REG_BASE_LO) begin
            base_reg[gb][7:0] <= PWDATA[7:0]; // RQ13
          end
        end
      end
    end
  endgenerate

  // ==========================================================================
  // pin level readback
  pcss_sync3 #(
    .WIDTH (NP)
  ) u_pin_sync (
    .clk      (CLK_SYS),
    .rst      (SYS_RST),
    .ce       (CLK_EN),
    .async_in (PIN_IN),
    .rst_val  (`PCSS_RST_DATA),
    .sync_out (pin_level)
  );

  // ==========================================================================
  // per-pin strobe generation
  assign ctrl_word = {ctrl_hi_reg, ctrl_lo_reg};

  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++) begin : g_pin
      assign pin_func[gp] = pcss_pkg::pcss_func_e'(
        ctrl_word[gp*`PCSS_FLD_PER_PIN+`PCSS_FUNC_LSB +: 2]); // RQ9 RQ10
      assign pin_cmp[gp]  = pcss_pkg::pcss_cmp_e'(
        ctrl_word[gp*`PCSS_FLD_PER_PIN+`PCSS_CMP_LSB +: 2]); // RQ9 RQ10

      pcss_addr_match u_match (
        .bus_addr  (BUS_ADDR),
        .base_addr (base_reg[gp]),
        .cmp_len   (pin_cmp[gp]),
        .addr_hit  (addr_hit[gp])
      );

      // qualified by the core strobe itself, so the width tracks that cycle
      always_comb begin
        unique case (pin_func[gp])
          pcss_pkg::PCSS_FUNC_GPIO: strobe_act[gp] = 1'b0;
          pcss_pkg::PCSS_FUNC_RD:   strobe_act[gp] = addr_hit[gp] && BUS_RD; // RQ2 RQ14
          pcss_pkg::PCSS_FUNC_WR:   strobe_act[gp] = addr_hit[gp] && BUS_WR; // RQ3 RQ14
          pcss_pkg::PCSS_FUNC_RDWR: strobe_act[gp] = addr_hit[gp] && (BUS_RD || BUS_WR); // RQ4 RQ14
        endcase
      end

      // registered output adds one cycle of lag to the strobe edges
      always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
          PIN_OUT[gp] <= 1'b1;
          PIN_OE[gp]  <= 1'b0;
        end else if (CLK_EN) begin
          if (pin_func[gp] == pcss_pkg::PCSS_FUNC_GPIO) begin
            // quasi-bidirectional: drive only a low, a one is the weak pull-up
            PIN_OUT[gp] <= data_reg[gp]; // RQ1 RQ15
            PIN_OE[gp]  <= !data_reg[gp]; // RQ1
          end else begin
            PIN_OUT[gp] <= strobe_act[gp] ? pol_reg[gp] : !pol_reg[gp]; // RQ11 RQ12 RQ16
            PIN_OE[gp]  <= 1'b1;
          end
        end
      end
    end
  endgenerate

endmodule // pcss_port_strobe

// *** tb/pcss_periph_model.sv ***
// far-side peripherals and pull-ups on the four strobe pins
`timescale 1ns/100ps
module pcss_periph_model (
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe,
  input  wire logic [3:0] ext_low,
  output logic      [3:0] pin_lvl
);
  // ==========================================================================
  // wire level
  // released pins float up, an outside part may still pull one low
  assign pin_lvl = ((pin_oe & pin_out) | ~pin_oe) & ~ext_low;
endmodule // pcss_periph_model

// *** tb/pcss_port_strobe_properties.sv ***
// assertion checker bound to the port strobe block
`timescale 1ns/100ps
`include "pcss_params.svh"
module pcss_port_strobe_chk #(
  parameter int PADDR_W = 12
) (
  input wire logic               CLK_SYS,
  input wire logic               SYS_RST,
  input wire logic               CLK_EN,
  input wire logic               PSEL,
  input wire logic               PENABLE,
  input wire logic               PWRITE,
  input wire logic [PADDR_W-1:0] PADDR,
  input wire logic [31:0]        PWDATA,
  input wire logic [3:0]         PSTRB,
  input wire logic [31:0]        PRDATA,
  input wire logic               PREADY,
  input wire logic               PSLVERR,
  input wire logic               BUS_RD,
  input wire logic               BUS_WR,
  input wire logic [3:0]         PIN_OUT,
  input wire logic [3:0]         PIN_OE
);
  // ==========================================================================
  // shadow of the mode fields, the checker sees no internals
  logic [15:0] ctrl_reg;
  logic [3:0]  pol_reg;
  logic        wr_ok;
  assign wr_ok = CLK_EN & PSEL & PENABLE & PREADY & PWRITE & PSTRB[0] & ~PSLVERR;
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ctrl_reg <= 16'h0000;
      pol_reg  <= 4'h0;
    end else if (wr_ok) begin
      if (PADDR[9:2] == `PCSS_IDX_CTRL_LO) ctrl_reg[7:0] <= PWDATA[7:0];
      if (PADDR[9:2] == `PCSS_IDX_CTRL_HI) ctrl_reg[15:8] <= PWDATA[7:0];
      if (PADDR[9:2] == `PCSS_IDX_POLARITY) pol_reg <= PWDATA[7:4];
    end
  end
  // ==========================================================================
  // properties
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  a_ready_wait: assert property (PSEL && !PENABLE && CLK_EN |=> !PREADY ##1 PREADY)
    else $error("ready timing wrong");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready too long");
  a_ready_req: assert property (PREADY |-> PSEL && PENABLE)
    else $error("ready without access");
  a_err_empty: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0000_0000)
    else $error("error answer wrong");
  a_rdata_upper: assert property (PREADY |-> PRDATA[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_reset_pins: assert property ($fell(SYS_RST) |-> PIN_OUT == 4'hF && PIN_OE == 4'h0)
    else $error("pins wrong after reset");
  a_pin_quiet: assert property ($changed(PIN_OUT) |-> $past(BUS_RD || BUS_WR) ||
    $past(BUS_RD || BUS_WR, 2) || $past(PREADY) || $past(PREADY, 2)) else $error("pin moved alone");
  for (genvar i = 0; i < 4; i++) begin : g_pin
    a_idle_level: assert property ($past(ctrl_reg[4*i+3 -: 2] != 2'b00) &&
      !$past(BUS_RD && ctrl_reg[4*i+2]) && !$past(BUS_WR && ctrl_reg[4*i+3])
      |-> PIN_OE[i] && PIN_OUT[i] == !$past(pol_reg[i])) else $error("strobe not idle");
    a_gpio_drive: assert property ($past(ctrl_reg[4*i+3 -: 2] == 2'b00) |-> PIN_OE[i] == !PIN_OUT[i])
      else $error("gpio drive wrong");
  end
  c_write: cover property (wr_ok);
  c_error: cover property (PSLVERR);
  c_strobe: cover property (BUS_WR && PIN_OE[0] && PIN_OUT[0]);
endmodule // pcss_port_strobe_chk

bind pcss_port_strobe pcss_port_strobe_chk #(.PADDR_W(PADDR_W)) u_chk (.*);

// *** tb/tb.sv ***
// self-checking bench for the port strobe block
`timescale 1ns/100ps
`include "pcss_params.svh"
module tb;
  logic        clk, rst, ce, psel, pen, pwr, brd, bwr, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] baddr;
  logic [7:0]  rd;
  logic [3:0]  pstrb, pin_in, pin_out, pin_oe, ext_low;
  int          failures, n_checks;
  logic [7:0]  lo_ix [4] = '{`PCSS_IDX_P0_BASE_LO, `PCSS_IDX_P1_BASE_LO,
                             `PCSS_IDX_P2_BASE_LO, `PCSS_IDX_P3_BASE_LO};
  pcss_port_strobe #(.PADDR_W(12)) dut (
    .CLK_SYS(clk), .SYS_RST(rst), .CLK_EN(ce), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .BUS_ADDR(baddr), .BUS_RD(brd), .BUS_WR(bwr),
    .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe));
  pcss_periph_model u_periph (.pin_out(pin_out), .pin_oe(pin_oe), .ext_low(ext_low), .pin_lvl(pin_in));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ==========================================================================
  // shared tasks
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(logic w, logic [7:0] idx, logic [7:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n == 16) chk("pready", 1'b0, 1'b1);
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // bus cycle then release, pin looked at one edge after each change
  task automatic cyc(logic [15:0] a, logic w, int p, logic e, logic pol);
    @(posedge clk);
    baddr <= a;
    brd <= !w;
    bwr <= w;
    @(posedge clk);
    #1;
    chk("strobe", {pin_oe[p], pin_out[p]}, {1'b1, e ~^ pol});
    @(posedge clk);
    brd <= 1'b0;
    bwr <= 1'b0;
    @(posedge clk);
    #1;
    chk("idle", {pin_oe[p], pin_out[p]}, {1'b1, !pol});
  endtask
  task automatic cfg(int p, logic [1:0] f, logic [1:0] c, logic pol);
    logic [15:0] cw;
    cw = 16'({f, c}) << (4 * p);
    apb(1'b1, lo_ix[p], 8'h34);
    apb(1'b1, lo_ix[p] + 8'h01, 8'h12);
    apb(1'b1, `PCSS_IDX_CTRL_LO, cw[7:0]);
    apb(1'b1, `PCSS_IDX_CTRL_HI, cw[15:8]);
    apb(1'b1, `PCSS_IDX_POLARITY, 8'(pol) << (4 + p));
  endtask
  function automatic logic hit(logic [15:0] a, logic [1:0] c);
    case (c)
      2'd0: hit = a == 16'h1234;
      2'd1: hit = a[15:1] == 15'h091A;
      2'd2: hit = a[15:2] == 14'h048D;
      default: hit = a[15:8] == 8'h12;
    endcase
  endfunction
  task automatic print_verdict;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_regs;
    logic [7:0] ix [11] = '{`PCSS_IDX_POLARITY, `PCSS_IDX_CTRL_LO, `PCSS_IDX_CTRL_HI,
      `PCSS_IDX_P0_BASE_LO, `PCSS_IDX_P0_BASE_HI, `PCSS_IDX_P1_BASE_LO, `PCSS_IDX_P1_BASE_HI,
      `PCSS_IDX_P2_BASE_LO, `PCSS_IDX_P2_BASE_HI, `PCSS_IDX_P3_BASE_LO, `PCSS_IDX_P3_BASE_HI};
    foreach (ix[i]) begin
      apb(1'b0, ix[i], 8'h00);
      chk("reset value", rd, 8'h00);
    end
    apb(1'b0, `PCSS_IDX_PORT_DATA, 8'h00);
    chk("pin levels", rd, 8'h0F);
    apb(1'b1, `PCSS_IDX_POLARITY, 8'hFF);
    apb(1'b0, `PCSS_IDX_POLARITY, 8'h00);
    chk("polarity", rd, 8'hF0);
    pstrb <= 4'h0;
    apb(1'b1, `PCSS_IDX_P2_BASE_HI, 8'hC3);
    pstrb <= 4'hF;
    apb(1'b1, `PCSS_IDX_P2_BASE_LO, 8'h5A);
    apb(1'b0, `PCSS_IDX_P2_BASE_HI, 8'h00);
    chk("masked write", rd, 8'h00);
    apb(1'b0, `PCSS_IDX_P2_BASE_LO, 8'h00);
    chk("base low", rd, 8'h5A);
    apb(1'b1, 8'h10, 8'h00);
    chk("slave error", er, 1'b1);
    $display("done regs");
  endtask
  task automatic t_gpio;
    apb(1'b1, `PCSS_IDX_PORT_DATA, 8'h05);
    @(posedge clk);
    ext_low <= 4'h1;
    #1;
    chk("gpio out", pin_out, 4'h5);
    chk("gpio oe", pin_oe, 4'hA);
    repeat (8) @(posedge clk);
    apb(1'b0, `PCSS_IDX_PORT_DATA, 8'h00);
    chk("pin read", rd, 8'h04);
    ext_low <= 4'h0;
    $display("done gpio");
  endtask
  // every pin, strobe mode and compare length, both polarities
  task automatic t_strobe;
    logic [15:0] pa [5] = '{16'h1234, 16'h1235, 16'h1237, 16'h12FF, 16'h1334};
    logic [1:0]  f, c;
    for (int p = 0; p < 4; p++)
      for (int i = 4; i < 16; i++) begin
        f = i[3:2];
        c = i[1:0];
        cfg(p, f, c, p[0] ^ c[0]);
        for (int k = 0; k < 5; k++)
          for (int w = 0; w < 2; w++)
            cyc(pa[k], w[0], p, hit(pa[k], c) && (w[0] ? f[1] : f[0]), p[0] ^ c[0]);
      end
    $display("done strobe");
  endtask
  // enable low holds the pin although a matching write cycle starts
  task automatic t_freeze;
    @(posedge clk);
    ce <= 1'b0;
    baddr <= 16'h1234;
    bwr <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("frozen pin", pin_out[3], 1'b1);
    @(posedge clk);
    ce <= 1'b1;
    @(posedge clk);
    #1;
    chk("enabled pin", pin_out[3], 1'b0);
    @(posedge clk);
    bwr <= 1'b0;
    @(posedge clk);
    #1;
    chk("released pin", pin_out[3], 1'b1);
    $display("done freeze");
  endtask
  // mid-run reset: back to gpio, readback must not dip after release
  task automatic t_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("reset pins", {pin_oe, pin_out}, 8'h0F);
    apb(1'b0, `PCSS_IDX_PORT_DATA, 8'h00);
    chk("readback after reset", rd, 8'h0F);
    apb(1'b0, `PCSS_IDX_CTRL_HI, 8'h00);
    chk("ctrl after reset", rd, 8'h00);
    apb(1'b0, `PCSS_IDX_P3_BASE_HI, 8'h00);
    chk("base after reset", rd, 8'h00);
    $display("done reset");
  endtask
  initial begin
    #250000;
    failures++;
    print_verdict;
  end
  initial begin
    failures = 0;
    n_checks = 0;
    rst = 1'b1;
    {psel, pen, pwr, brd, bwr} = 5'h00;
    ce = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    baddr = 16'h0000;
    ext_low = 4'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_gpio;
    t_strobe;
    t_freeze;
    t_reset;
    print_verdict;
  end
endmodule // tb
